// file: logic/ccms_clock_mode_select.sv
/*
   cpu clock generation: mode latch from port 0 upper byte, prescaler,
   direct drive and a counter model of the pll.
   assumes osc_in is sampled synchronously at ref_clk and ref_clk is at
   least 2F times faster than the oscillator; long_reset_n marks a long reset.
*/
// Operation
// - every cpu clock edge starts a phase; phase_edge pulses on both edges.
// - mode taken from bits 7 to 5 of the upper reset configuration.
// - long reset loads upper configuration from port 0 upper byte pins.
// - encodings 111 x4,110 x3,101 x2,100 x5,011 x1,010 x1.5,001 /2,000 x2.5.
// - prescaler mode toggles cpu clock once per oscillator period.
// - multiplying modes enable pll, output oscillator frequency times factor.
// - pll resyncs to oscillator every F-th transition, period reloaded from each measured oscillator period.
// - direct drive disables pll, cpu clock follows oscillator input.
// - two consecutive direct drive phases equal one oscillator period.
`timescale 1ns/1ns
`include "ccms_regs.svh"
module ccms_clock_mode_select (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic long_reset_n,
   input wire logic [7:0] port0_upper_byte,
   input wire logic osc_in,
   output logic cpu_clk,
   output logic phase_edge,
   output logic pll_enable,
   output logic [2:0] clock_mode_select,
   output logic [7:0] reset_config_upper,
   output ccms_pkg::ccms_status_t status
);
   // ----------------------------------------
   // reset configuration latch
   // ----------------------------------------
   logic [7:0] cfg_r, cfg_nxt;
   always_comb begin
      cfg_nxt = cfg_r;
      // capture while long reset held; frozen after release
      if (!long_reset_n) begin
         cfg_nxt = port0_upper_byte;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= `CCMS_CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end
   logic [2:0] mode;
   assign mode = cfg_r[`CCMS_MODE_MSB:`CCMS_MODE_LSB];
   ccms_pkg::ccms_src_t src;
   logic [3:0] num; // cpu phases per oscillator period (2F)
   always_comb begin
      num = `CCMS_NUM_X4;
      src = ccms_pkg::CCMS_SRC_PLL;
      unique case (mode)
         `CCMS_MODE_X4: num = `CCMS_NUM_X4;
         `CCMS_MODE_X3: num = `CCMS_NUM_X3;
         `CCMS_MODE_X2: num = `CCMS_NUM_X2;
         `CCMS_MODE_X5: num = `CCMS_NUM_X5;
         `CCMS_MODE_DIRECT: src = ccms_pkg::CCMS_SRC_DIRECT;
         `CCMS_MODE_X1P5: num = `CCMS_NUM_X1P5;
         `CCMS_MODE_PRESCALE: src = ccms_pkg::CCMS_SRC_PRESCALE;
         `CCMS_MODE_X2P5: num = `CCMS_NUM_X2P5;
      endcase
   end
   // ----------------------------------------
   // oscillator edge detect and period measure
   // ----------------------------------------
   logic osc_r, osc_nxt;
   logic osc_rise, osc_edge;
   assign osc_edge = osc_in ^ osc_r;
   assign osc_rise = osc_in & ~osc_r;
   logic [11:0] per_cnt_r, per_cnt_nxt, per_r, per_nxt;
   always_comb begin
      osc_nxt = osc_in;
      per_cnt_nxt = (per_cnt_r == 12'hFFF) ? per_cnt_r : per_cnt_r + 12'h001;
      per_nxt = per_r;
      if (osc_rise) begin
         per_cnt_nxt = 12'h001;
         per_nxt = per_cnt_r;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_r <= 1'b0;
         per_cnt_r <= 12'h001;
         per_r <= 12'h000;
      end else begin
         osc_r <= osc_nxt;
         per_cnt_r <= per_cnt_nxt;
         per_r <= per_nxt;
      end
   end
   // ----------------------------------------
   // cpu clock generation
   // ----------------------------------------
   // pll modelled as a phase accumulator: num per ref_clk cycle, toggle on each
   // wrap at per, so 2F phases per period; steps hide jitter, resync jumps the accumulator to 0 or half_tgt.
   logic [15:0] acc_r, acc_nxt, wrap, half_tgt;
   logic [3:0] trans_r, trans_nxt;
   logic pclk_r, pclk_nxt, div_r, div_nxt, cpu_r, cpu_nxt;
   logic [15:0] step_sum;
   assign wrap = {4'h0, per_r};
   // phase expected at an oscillator fall: odd 2F leaves half a wrap
   assign half_tgt = num[0] ? {5'h00, per_r[11:1]} : 16'h0000;
   assign step_sum = acc_r + {12'h000, num};
   always_comb begin
      acc_nxt = acc_r;
      pclk_nxt = pclk_r;
      trans_nxt = trans_r;
      div_nxt = div_r;
      if (osc_rise) begin
         div_nxt = ~div_r;
      end
      if (step_sum >= wrap && wrap != 16'h0000) begin
         acc_nxt = step_sum - wrap;
         pclk_nxt = ~pclk_r;
      end else begin
         acc_nxt = step_sum;
      end
      // realign accumulator after F oscillator transitions (2F/2)
      if (osc_edge) begin
         if (trans_r + 4'h2 >= num) begin
            trans_nxt = 4'h0;
            if (osc_rise) begin
               acc_nxt = 16'h0000;
            end else begin
               acc_nxt = half_tgt;
            end
         end else begin
            trans_nxt = trans_r + 4'h2;
         end
      end
      unique case (src)
         ccms_pkg::CCMS_SRC_DIRECT: cpu_nxt = osc_in;
         ccms_pkg::CCMS_SRC_PRESCALE: cpu_nxt = div_nxt;
         ccms_pkg::CCMS_SRC_PLL: cpu_nxt = pclk_nxt;
         default: cpu_nxt = 1'b0;
      endcase
      if (!long_reset_n) begin
         cpu_nxt = 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_r <= 16'h0000;
         pclk_r <= 1'b0;
         trans_r <= 4'h0;
         div_r <= 1'b0;
         cpu_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         pclk_r <= pclk_nxt;
         trans_r <= trans_nxt;
         div_r <= div_nxt;
         cpu_r <= cpu_nxt;
      end
   end
   logic cpu_d_r;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_d_r <= 1'b0;
      end else begin
         cpu_d_r <= cpu_r;
      end
   end
   assign cpu_clk = cpu_r;
   assign phase_edge = cpu_r ^ cpu_d_r;
   assign pll_enable = (src == ccms_pkg::CCMS_SRC_PLL);
   assign clock_mode_select = mode;
   assign reset_config_upper = cfg_r;
   assign status = '{cpu_clk: cpu_r, phase_edge: phase_edge, pll_enable: pll_enable, mode: mode};
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_cfg_hold;
      @(posedge ref_clk) disable iff (!reset_n) long_reset_n && $past(long_reset_n) |-> $stable(cfg_r);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed outside long reset");
   property p_cfg_load;
      @(posedge ref_clk) disable iff (!reset_n) !long_reset_n |=> cfg_r == $past(port0_upper_byte);
   endproperty
   a_cfg_load: assert property (p_cfg_load) else $error("config not loaded from port");
   property p_mode_field;
      @(posedge ref_clk) disable iff (!reset_n)
         clock_mode_select == reset_config_upper[`CCMS_MODE_MSB:`CCMS_MODE_LSB];
   endproperty
   a_mode_field: assert property (p_mode_field) else $error("mode not from bits 7..5");
   property p_direct;
      @(posedge ref_clk) disable iff (!reset_n)
         long_reset_n && mode == `CCMS_MODE_DIRECT |=> cpu_clk == $past(osc_in);
   endproperty
   a_direct: assert property (p_direct) else $error("direct drive not following oscillator");
   property p_direct_pll_off;
      @(posedge ref_clk) disable iff (!reset_n)
         (mode == `CCMS_MODE_DIRECT || mode == `CCMS_MODE_PRESCALE) |-> !pll_enable;
   endproperty
   a_direct_pll_off: assert property (p_direct_pll_off) else $error("pll on in non-pll mode");
   property p_pll_on;
      @(posedge ref_clk) disable iff (!reset_n)
         (mode != `CCMS_MODE_DIRECT && mode != `CCMS_MODE_PRESCALE) |-> pll_enable;
   endproperty
   a_pll_on: assert property (p_pll_on) else $error("pll off in multiplying mode");
   property p_prescale;
      @(posedge ref_clk) disable iff (!reset_n)
         long_reset_n && mode == `CCMS_MODE_PRESCALE && osc_rise |=> cpu_clk != $past(cpu_clk);
   endproperty
   a_prescale: assert property (p_prescale) else $error("prescaler missed oscillator period");
   property p_edge_pulse;
      @(posedge ref_clk) disable iff (!reset_n) phase_edge == $changed(cpu_clk);
   endproperty
   a_edge_pulse: assert property (p_edge_pulse) else $error("phase edge missing");
   property p_dir_pair;
      @(posedge ref_clk) disable iff (!reset_n)
         long_reset_n && mode == `CCMS_MODE_DIRECT && osc_rise |=> cpu_clk;
   endproperty
   a_dir_pair: assert property (p_dir_pair) else $error("direct pair not aligned to period");
   property p_resync;
      @(posedge ref_clk) disable iff (!reset_n) pll_enable && osc_rise && trans_r + 4'h2 >= num |=> acc_r == 16'h0000;
   endproperty
   a_resync: assert property (p_resync) else $error("pll not resynchronised");
   property p_resync_fall;
      @(posedge ref_clk) disable iff (!reset_n)
         pll_enable && osc_edge && !osc_rise && trans_r + 4'h2 >= num |=> acc_r == $past(half_tgt);
   endproperty
   a_resync_fall: assert property (p_resync_fall) else $error("pll not resynchronised on fall");
   c_pll: cover property (@(posedge ref_clk) pll_enable && phase_edge);
   c_direct: cover property (@(posedge ref_clk) mode == `CCMS_MODE_DIRECT && phase_edge);
   c_prescale: cover property (@(posedge ref_clk) mode == `CCMS_MODE_PRESCALE && phase_edge);
   c_resync: cover property (@(posedge ref_clk) pll_enable && osc_edge && trans_r + 4'h2 >= num);
endmodule // ccms_clock_mode_select

// file: logic/ccms_pkg.sv
/*
   types for the cpu clock mode selector.
   assumes ccms_regs.svh on the include path.
*/
package ccms_pkg;
   typedef enum logic [2:0] {
      CCMS_SRC_PLL = 3'h1,
      CCMS_SRC_DIRECT = 3'h2,
      CCMS_SRC_PRESCALE = 3'h4
   } ccms_src_t;
   typedef struct packed {
      logic cpu_clk;
      logic phase_edge;
      logic pll_enable;
      logic [2:0] mode;
   } ccms_status_t;
endpackage

// file: logic/ccms_regs.svh
/*
   clock mode select constants: field positions, encodings, reset values.
   assumes inclusion by bare name from the design module.
*/
`ifndef CCMS_REGS_SVH
`define CCMS_REGS_SVH
// ----------------------------------------
// reset configuration field layout
// ----------------------------------------
`define CCMS_MODE_MSB 7
`define CCMS_MODE_LSB 5
`define CCMS_CFG_RESET 8'hFF
// ----------------------------------------
// mode encodings
// ----------------------------------------
`define CCMS_MODE_X4 3'h7
`define CCMS_MODE_X3 3'h6
`define CCMS_MODE_X2 3'h5
`define CCMS_MODE_X5 3'h4
`define CCMS_MODE_DIRECT 3'h3
`define CCMS_MODE_X1P5 3'h2
`define CCMS_MODE_PRESCALE 3'h1
`define CCMS_MODE_X2P5 3'h0
// ----------------------------------------
// pll model: cpu phases per oscillator phase, times 2 (=2F)
// ----------------------------------------
`define CCMS_NUM_X4 4'h8
`define CCMS_NUM_X3 4'h6
`define CCMS_NUM_X2 4'h4
`define CCMS_NUM_X5 4'hA
`define CCMS_NUM_X1P5 4'h3
`define CCMS_NUM_X2P5 4'h5
`endif

// file: verif/ccms_clock_mode_select_tb.sv
/*
   self checking bench for the cpu clock mode selector.
   assumes ccms_osc_model with a 40 cycle oscillator period.
*/
`timescale 1ns/1ns
module ccms_clock_mode_select_tb;
   // ----------------------------------------
   // stimulus and instances
   // ----------------------------------------
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic long_reset_n = 1'b1;
   logic [7:0] port0_upper_byte = 8'h00;
   logic osc_in, cpu_clk, phase_edge, pll_enable;
   logic [2:0] clock_mode_select;
   logic [7:0] reset_config_upper;
   ccms_pkg::ccms_status_t status;
   int fail_count = 0;
   int compares = 0;
   always #2 ref_clk = ~ref_clk;
   ccms_osc_model ccms_osc_model_inst (.ref_clk(ref_clk), .osc_in(osc_in));
   ccms_clock_mode_select ccms_clock_mode_select_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .long_reset_n(long_reset_n), .port0_upper_byte(port0_upper_byte), .osc_in(osc_in),
      .cpu_clk(cpu_clk), .phase_edge(phase_edge), .pll_enable(pll_enable),
      .clock_mode_select(clock_mode_select), .reset_config_upper(reset_config_upper), .status(status));
   // ----------------------------------------
   // compare and helper tasks
   // ----------------------------------------
   task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic cmp_cnt(input int got, input int exp, input int tol, input string msg);
      compares++;
      if (got < exp - tol || got > exp + tol) begin
         fail_count++;
         $display("[FAIL] %0t %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask
   task automatic complete_run;
      if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic configure(input logic [7:0] p);
      @(negedge ref_clk);
      long_reset_n = 1'b0;
      port0_upper_byte = p;
      repeat (2) @(negedge ref_clk);
      long_reset_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      cmp_val(reset_config_upper, p, "cfg");
      cmp_val({5'h00, clock_mode_select}, {5'h00, p[7:5]}, "mode");
      cmp_val({5'h00, status.mode}, {5'h00, p[7:5]}, "status mode");
      repeat (200) @(negedge ref_clk);
   endtask
   // toggles of cpu_clk over n cycles; phase_edge checked in the cycle of each
   task automatic measure(input int n, output int tg);
      logic last;
      logic ch;
      tg = 0;
      last = cpu_clk;
      ch = 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         #1;
         ch = (cpu_clk !== last);
         cmp_val({7'h00, phase_edge}, {7'h00, ch}, "phase edge");
         cmp_val({7'h00, status.phase_edge}, {7'h00, ch}, "status edge");
         if (ch) tg++;
         last = cpu_clk;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      cmp_val(reset_config_upper, 8'hFF, "reset cfg");
      cmp_val({7'h00, pll_enable}, 8'h01, "reset pll");
   endtask
   task automatic t_direct;
      int tg;
      logic o;
      configure(8'h75);
      cmp_val({7'h00, pll_enable}, 8'h00, "direct pll");
      for (int i = 0; i < 80; i++) begin
         @(posedge ref_clk);
         o = osc_in;
         #1;
         cmp_val({7'h00, cpu_clk}, {7'h00, o}, "direct follow");
         cmp_val({7'h00, status.cpu_clk}, {7'h00, o}, "status clock");
      end
      measure(160, tg);
      cmp_cnt(tg, 8, 0, "direct phases");
      @(negedge ref_clk);
      port0_upper_byte = 8'h3A;
      repeat (4) @(negedge ref_clk);
      cmp_val(reset_config_upper, 8'h75, "held cfg");
   endtask
   task automatic t_prescale;
      int tg;
      configure(8'h3A);
      cmp_val({7'h00, pll_enable}, 8'h00, "prescale pll");
      measure(160, tg);
      cmp_cnt(tg, 4, 0, "prescale phases");
   endtask
   // 2F toggles per 40 cycle oscillator period, num holds 2F
   task automatic t_pll;
      logic [2:0] md [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
      int num [6] = '{8, 6, 4, 10, 3, 5};
      int tg;
      for (int k = 0; k < 6; k++) begin
         configure({md[k], 5'h0A});
         cmp_val({7'h00, pll_enable}, 8'h01, "pll on");
         measure(160, tg);
         cmp_cnt(tg, 4 * num[k], 1, "pll phases");
      end
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (2) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      t_reset();
      t_direct();
      t_prescale();
      t_pll();
      complete_run();
   end
   initial begin
      #40000;
      fail_count++;
      complete_run();
   end
endmodule // ccms_clock_mode_select_tb

// file: verif/ccms_osc_model.sv
/*
   oscillator stand-in driving osc_in with a fixed half period.
   assumes the bench clock ref_clk; osc changes on falling edges only.
*/
`timescale 1ns/1ns
module ccms_osc_model #(
   parameter int HALF_CYC = 20
) (
   input wire logic ref_clk,
   output logic osc_in
);
   // ----------------------------------------
   // free running square wave
   // ----------------------------------------
   int cnt;
   initial begin
      osc_in = 1'b0;
      cnt = 0;
   end
   // slow enough for the 2F*2 cycle budget of x5
   always @(negedge ref_clk) begin
      cnt = (cnt == HALF_CYC - 1) ? 0 : cnt + 1;
      if (cnt == 0) begin
         osc_in = ~osc_in;
      end
   end
endmodule // ccms_osc_model
